// ===== include/pss_pkg.sv
// Constants shared by the pipelined synchronous SRAM port.
// Assumes one clock, ref_clk, and a synchronous active-high reset.
package pss_pkg;
    localparam int ADDR_WIDTH = 17;
    localparam int LANE_COUNT = 4;
    localparam int LANE_WIDTH = 9;
    localparam int DATA_PIPE_DEPTH = 2;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] BURST_START = 2'h0;

    typedef enum logic [4:0] {
        OP_IDLE  = 5'b0_0001,
        OP_READ  = 5'b0_0010,
        OP_WRITE = 5'b0_0100,
        OP_DESEL = 5'b0_1000,
        OP_NOOP  = 5'b1_0000
    } pss_op_type;
endpackage

// ===== logic/pss_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module pss_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doPush;
    logic doPop;

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0
                             : wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0
                             : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

// ===== logic/pss_sram_port.sv
// Pipelined synchronous SRAM port: control decode, burst counter,
// two-stage data pipeline and byte-lane writes into a local array.
// Read data leaves through a FIFO toward an internal consumer port.
// Assumes the controller obeys the two-cycle data timing.
module pss_sram_port
    import pss_pkg::*;
#(
    parameter int ADDR_WIDTH_P = pss_pkg::ADDR_WIDTH,
    parameter int LANES = pss_pkg::LANE_COUNT,
    parameter int MEM_WORDS = 1024
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clockGateLow,
    input wire logic advanceOrLoad,
    input wire logic dirSelect,
    input wire logic chipSelALow,
    input wire logic chipSelBLow,
    input wire logic chipSelCHigh,
    input wire logic burstOrderSelect,
    input wire logic [ADDR_WIDTH_P-1:0] addr,
    input wire logic [LANES-1:0] byteWriteStrobeLow,
    input wire logic [LANES*pss_pkg::LANE_WIDTH-1:0] dataIn,
    output logic [LANES*pss_pkg::LANE_WIDTH-1:0] dataOut,
    output logic dataOutEn,
    output logic readValid,
    input wire logic readReady,
    output logic [LANES*pss_pkg::LANE_WIDTH-1:0] readData
);
    import pss_pkg::*;

    localparam int DW = LANES * LANE_WIDTH;
    localparam int MW = $clog2(MEM_WORDS);

    ////////////////////////////////////////////////////////////////////
    // Cycle decode.

    logic [DW-1:0] mem [MEM_WORDS];
    logic selected;
    logic active;
    logic fifoReady;
    pss_op_type op_reg;
    pss_op_type opNow;
    logic [ADDR_WIDTH_P-1:0] baseAddr_reg;
    logic [1:0] burstCount_reg;
    logic [1:0] lowBits;
    logic [ADDR_WIDTH_P-1:0] beatAddr;
    logic [LANES-1:0] beatStrobe;

    // A full read FIFO stalls the port like a gated edge, so no read
    // result is ever dropped; this trades throughput for safety.
    assign active = !clockGateLow && fifoReady;
    assign selected = !chipSelALow && !chipSelBLow && chipSelCHigh;

    always_comb begin
        opNow = OP_IDLE;
        beatStrobe = '1;
        if (!advanceOrLoad) begin
            if (!selected) begin
                opNow = OP_DESEL;
            end else begin
                opNow = dirSelect ? OP_READ : OP_WRITE;
            end
            beatStrobe = byteWriteStrobeLow;
        end else begin
            case (op_reg)
                // Direction is held from the load, not resampled.
                OP_READ: opNow = OP_READ;
                OP_WRITE: opNow = OP_WRITE;
                OP_DESEL, OP_NOOP, OP_IDLE: opNow = OP_NOOP;
                default: opNow = OP_NOOP;
            endcase
            beatStrobe = byteWriteStrobeLow;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address and burst counter.

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_reg <= OP_IDLE;
            baseAddr_reg <= '0;
            burstCount_reg <= BURST_START;
        end else if (active) begin
            op_reg <= opNow;
            if (!advanceOrLoad && selected) begin
                baseAddr_reg <= addr;
                burstCount_reg <= BURST_START;
            end else if (advanceOrLoad) begin
                // Two bits wrap naturally after the fourth beat.
                burstCount_reg <= burstCount_reg + 2'h1;
            end
        end
    end

    always_comb begin
        if (burstOrderSelect) begin
            lowBits = baseAddr_reg[1:0] ^ burstCount_reg;
        end else begin
            lowBits = baseAddr_reg[1:0] + burstCount_reg;
        end
        beatAddr = {baseAddr_reg[ADDR_WIDTH_P-1:2], lowBits};
    end

    ////////////////////////////////////////////////////////////////////
    // Two-stage pipeline carrying each cycle to its data slot.

    // The decoded-cycle register counts as the first pipeline stage, so
    // the array holds only the stages behind it.
    pss_op_type pipeOp_reg [DATA_PIPE_DEPTH-1];
    logic [ADDR_WIDTH_P-1:0] pipeAddr_reg [DATA_PIPE_DEPTH-1];
    logic [LANES-1:0] pipeStrobe_reg [DATA_PIPE_DEPTH-1];
    pss_op_type stageOp;
    logic [ADDR_WIDTH_P-1:0] stageAddr;
    logic [LANES-1:0] stageStrobe;
    logic [LANES-1:0] strobeHold_reg;

    // Stage 0 holds what was decoded at the previous edge; its address
    // is the one the counter presents for that beat.
    always_comb begin
        stageOp = op_reg;
        stageAddr = (op_reg == OP_READ || op_reg == OP_WRITE) ? beatAddr
                    : '0;
        stageStrobe = strobeHold_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strobeHold_reg <= '1;
        end else if (active) begin
            strobeHold_reg <= beatStrobe;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DATA_PIPE_DEPTH - 1; i++) begin
                pipeOp_reg[i] <= OP_IDLE;
                pipeAddr_reg[i] <= '0;
                pipeStrobe_reg[i] <= '1;
            end
        end else if (active) begin
            pipeOp_reg[0] <= stageOp;
            pipeAddr_reg[0] <= stageAddr;
            pipeStrobe_reg[0] <= stageStrobe;
            for (int i = 1; i < DATA_PIPE_DEPTH - 1; i++) begin
                pipeOp_reg[i] <= pipeOp_reg[i-1];
                pipeAddr_reg[i] <= pipeAddr_reg[i-1];
                pipeStrobe_reg[i] <= pipeStrobe_reg[i-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data slot: write lanes, drive read data.

    pss_op_type slotOp;
    logic [ADDR_WIDTH_P-1:0] slotAddr;
    logic [LANES-1:0] slotStrobe;
    logic [MW-1:0] slotIndex;
    logic [DW-1:0] readWord;

    assign slotOp = pipeOp_reg[DATA_PIPE_DEPTH-2];
    assign slotAddr = pipeAddr_reg[DATA_PIPE_DEPTH-2];
    assign slotStrobe = pipeStrobe_reg[DATA_PIPE_DEPTH-2];
    assign slotIndex = slotAddr[MW-1:0];
    assign readWord = mem[slotIndex];

    // The lane count parameter sets how many strobes exist; with two
    // lanes the upper strobes and lanes simply are not built.
    always_ff @(posedge ref_clk) begin
        if (active && slotOp == OP_WRITE) begin
            for (int l = 0; l < LANES; l++) begin
                if (!slotStrobe[l]) begin
                    mem[slotIndex][l*LANE_WIDTH +: LANE_WIDTH] <=
                        dataIn[l*LANE_WIDTH +: LANE_WIDTH];
                end
            end
        end
    end

    // The bus keeps driving data for operations already in flight and
    // floats once any non-read cycle (write, deselect, noop or idle) reaches the data slot.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dataOut <= '0;
            dataOutEn <= 1'b0;
        end else if (active) begin
            dataOutEn <= (slotOp == OP_READ);
            if (slotOp == OP_READ) begin
                dataOut <= readWord;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read results also stream out through the FIFO.

    logic pushRead;
    assign pushRead = active && slotOp == OP_READ;

    pss_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) readFifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .inValid(pushRead),
        .inReady(fifoReady),
        .inData(readWord),
        .outValid(readValid),
        .outReady(readReady),
        .outData(readData)
    );
endmodule

// ===== sim/pss_sram_port_asserts.sv
// Checker for the SRAM port output pipeline.
// Sees only the port's pins and is bound into every port instance.
module pss_sram_port_asserts
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clockGateLow,
    input wire logic advanceOrLoad,
    input wire logic dirSelect,
    input wire logic chipSelALow,
    input wire logic chipSelBLow,
    input wire logic chipSelCHigh,
    input wire logic [LANE_COUNT*LANE_WIDTH-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic readValid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire sel = !chipSelALow && !chipSelBLow && chipSelCHigh;
    ////////////////////////////////
    sequence go; !clockGateLow; endsequence
    sequence ldRd; go and (!advanceOrLoad && sel && dirSelect); endsequence
    sequence ldWr; go and (!advanceOrLoad && sel && !dirSelect); endsequence
    sequence desel; go and (!advanceOrLoad && !sel); endsequence
    sequence adv; go and advanceOrLoad; endsequence
    read_drive_a: assert property (ldRd ##1 go ##1 go |=> dataOutEn)
        else $error("read beat not driven");
    write_float_a: assert property (ldWr ##1 go ##1 go |=> !dataOutEn)
        else $error("write beat driven");
    burst_dir_a: assert property (
        ldRd ##1 (adv and !dirSelect) ##1 go ##1 go |=> dataOutEn)
        else $error("burst read lost");
    desel_float_a: assert property (desel ##1 go ##1 go |=> !dataOutEn)
        else $error("bus not released");
    noop_float_a: assert property (desel ##1 adv ##1 go[*2] |=> !dataOutEn)
        else $error("noop drove bus");
    gate_freeze_a: assert property (clockGateLow |=>
        $stable(dataOut) && $stable(dataOutEn)) else $error("gated edge moved");
    reset_float_a: assert property (disable iff (1'b0)
        sys_rst |=> !dataOutEn && !readValid) else $error("driven in reset");
    push_valid_a: assert property ($rose(dataOutEn) |-> readValid)
        else $error("read beat not queued");
endmodule
bind pss_sram_port pss_sram_port_asserts chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clockGateLow(clockGateLow),
    .advanceOrLoad(advanceOrLoad), .dirSelect(dirSelect),
    .chipSelALow(chipSelALow), .chipSelBLow(chipSelBLow),
    .chipSelCHigh(chipSelCHigh), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .readValid(readValid));

// ===== sim/pss_ctrl_model.sv
// Controller model: supplies write data two taken edges after a beat.
// Assumes the bench queues each write word when it issues the beat.
module pss_ctrl_model
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clockGateLow,
    input wire logic advanceOrLoad,
    input wire logic dirSelect,
    input wire logic sel,
    output logic [LANE_COUNT*LANE_WIDTH-1:0] dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [LANE_COUNT*LANE_WIDTH-1:0] q [$];
    logic inWr = 0;
    logic [1:0] slot = 2'h0;
    task push(input logic [LANE_COUNT*LANE_WIDTH-1:0] d);
        q.push_back(d);
    endtask
    initial dataIn = '0;
    ////////////////////////////////
    // A gated edge is ignored here too, so the data slot slides with it.
    always @(posedge ref_clk) begin
        if (!clockGateLow) begin
            if (!advanceOrLoad) inWr = sel && !dirSelect;
            slot = {slot[0], inWr};
            // Outside its slot the bus inverts its previous value on every taken edge.
            dataIn <= slot[1] && q.size() > 0 ? q.pop_front() : ~dataIn;
        end
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the pipelined SRAM port.
// Assumes the controller model drives write data for every write beat.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pss_pkg::*;
    localparam int W = LANE_COUNT*LANE_WIDTH;
    logic ref_clk = 0, sys_rst = 1, gate = 0, adv = 0, dir = 1, oe, rv;
    logic csA = 1, csB = 1, csC = 0, order = 0, rdy = 0, act = 0, wr = 0;
    logic [16:0] ad = 17'h0_0000, base;
    logic [3:0] bw = 4'hf;
    logic [1:0] k;
    logic [8:0] nw = 9'h011;
    logic [W-1:0] din, dout, rdat, bm [0:1023], fq [$];
    logic [W:0] p [0:2];
    logic [2:0] cp [3] = '{3'b100, 3'b010, 3'b000};
    int failures = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    pss_sram_port uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clockGateLow(gate), .advanceOrLoad(adv), .dirSelect(dir),
        .chipSelALow(csA), .chipSelBLow(csB), .chipSelCHigh(csC),
        .burstOrderSelect(order), .addr(ad), .byteWriteStrobeLow(bw),
        .dataIn(din), .dataOut(dout), .dataOutEn(oe), .readValid(rv),
        .readReady(rdy), .readData(rdat));
    pss_ctrl_model ctl (.ref_clk(ref_clk), .clockGateLow(gate),
        .advanceOrLoad(adv), .dirSelect(dir), .sel(!csA && !csB && csC),
        .dataIn(din));
    ////////////////////////////////
    task automatic chk(string n, logic [W-1:0] e, logic [W-1:0] g);
        n_compared++;
        if (e !== g) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Each call checks the beat issued three ungated calls back, then drives.
    task automatic cyc(logic g, a, d, logic [2:0] cs, logic [16:0] x,
                       logic [3:0] b);
        logic [16:0] m;
        logic [W-1:0] w;
        @(negedge ref_clk);
        chk("dataOutEn", p[2][W], oe);
        if (p[2][W]) chk("dataOut", p[2][W-1:0], dout);
        {gate, adv, dir, csA, csB, csC, ad, bw} = {g, a, d, cs, x, b};
        if (g) return;
        if (!a) begin
            act = cs == 3'b001;
            wr = !d;
            base = x;
            k = 2'h0;
        end else k = k + 2'h1;
        m = {base[16:2], order ? base[1:0] ^ k : base[1:0] + k};
        w = {nw, nw + 9'h003, nw ^ 9'h05A, ~nw};
        if (act && wr) begin
            ctl.push(w);
            for (int l = 0; l < LANE_COUNT; l++)
                if (!b[l]) bm[m[9:0]][l*LANE_WIDTH +: LANE_WIDTH] =
                    w[l*LANE_WIDTH +: LANE_WIDTH];
            nw = nw + 9'h037;
        end
        p[2] = p[1];
        p[1] = p[0];
        p[0] = {act && !wr, bm[m[9:0]]};
        if (act && !wr) fq.push_back(bm[m[9:0]]);
    endtask
    task t_write;
        cyc(0, 0, 0, 3'b001, 17'h0_0021, 4'h0);
        for (int i = 0; i < 4; i++) cyc(0, 1, 1, 3'b110, 0, 4'h0);
        cyc(0, 0, 0, 3'b001, 17'h0_0022, 4'b1110);
        cyc(0, 1, 1, 3'b110, 0, 4'b0101);
        cyc(0, 1, 1, 3'b110, 0, 4'hf);
        cyc(0, 1, 0, 3'b110, 0, 4'b1001);
        $display("t_write done");
    endtask
    task t_gate;
        cyc(0, 0, 1, 3'b001, 17'h0_0023, 4'h0);
        cyc(1, 0, 0, 3'b001, 17'h0_0020, 4'h0);
        cyc(0, 1, 0, 3'b001, 0, 4'h0);
        cyc(1, 0, 0, 3'b001, 17'h0_0021, 4'h0);
        cyc(1, 1, 0, 3'b001, 0, 4'h0);
        cyc(0, 1, 0, 3'b001, 0, 4'h0);
        $display("t_gate done");
    endtask
    task t_desel;
        foreach (cp[i]) begin
            cyc(0, 0, 1, 3'b001, 17'h0_0020, 4'h0);
            cyc(0, 0, 0, cp[i], 17'h0_0023, 4'h0);
            cyc(0, 1, 1, 3'b001, 0, 4'h0);
        end
        $display("t_desel done");
    endtask
    task t_read;
        for (int o = 0; o < 2; o++) begin
            repeat (2) cyc(0, 0, 0, 3'b100, 0, 4'h0);
            order = o[0];
            cyc(0, 0, 1, 3'b001, 17'h0_0021, 4'h0);
            for (int i = 0; i < 3; i++) cyc(0, 1, 0, 3'b001, 0, 4'h0);
        end
        $display("t_read done");
    endtask
    task t_fifo;
        repeat (4) cyc(0, 0, 0, 3'b100, 0, 4'h0);
        for (int i = 0; i < 40 && fq.size() > 0; i++) begin
            @(negedge ref_clk);
            if (rv === 1'b1) chk("readData", fq.pop_front(), rdat);
            rdy = 1;
        end
        @(negedge ref_clk);
        chk("readValid", 0, rv);
        chk("fifoLeft", 0, fq.size());
        $display("t_fifo done");
    endtask
    task end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        p = '{default: '0};
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 0;
        chk("dataOutEn", 0, oe);
        t_write;
        t_gate;
        t_desel;
        t_read;
        t_fifo;
        end_of_test;
    end
endmodule
